// ---- inc/apc_consts.svh ----
// Constants for the audio port clock master control block.
// Assumes inclusion by bare name from the include path.
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

// Register offsets
`define APC_OFS_OUT_EN 8'h08
`define APC_OFS_DIR_POL 8'h09
`define APC_OFS_DIV_RST 8'h0c

// Output enable control fields
`define APC_BIT_SER_OUT_OE 5
`define APC_BIT_MUTE_FWD 4

// Direction and polarity fields
`define APC_BIT_BCLK_INV 5
`define APC_BIT_BCLK_OE 4
`define APC_BIT_FCLK_OE 0

// Divider reset control fields
`define APC_BIT_BCLK_RUN 1
`define APC_BIT_FCLK_RUN 0

// Reset values
`define APC_RST_OUT_EN 8'h00
`define APC_RST_DIR_POL 8'h00
`define APC_RST_DIV_RST 8'h01

// Smallest usable divide ratio
`define APC_MIN_RATIO 8'h02

`endif

// ---- inc/apc_pkg.sv ----
// Types and helpers for the audio port clock master control block.
// Assumes apc_consts.svh is on the include path.
`include "apc_consts.svh"

package apc_pkg;

    // Register byte
    typedef logic [7:0] apc_byte_t;

    // Divide ratio, in input clock ticks per output period
    typedef logic [7:0] apc_ratio_t;

    // Clamp a ratio to the smallest one that yields a clock
    function automatic apc_ratio_t apc_eff_ratio(input apc_ratio_t r);
        apc_eff_ratio = (r < `APC_MIN_RATIO) ? `APC_MIN_RATIO : r;
    endfunction : apc_eff_ratio

endpackage : apc_pkg

// ---- core/apc_clk_divider.sv ----
// Programmable clock divider producing a level and edge pulses.
// Assumes tick_i is a per-cycle count enable in the core clock domain.
`timescale 1ns/1ns

module apc_clk_divider
    import apc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Control
    input wire logic run_i,
    input wire logic tick_i,
    input wire apc_ratio_t ratio_i,
    // Generated clock
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    ////////////////////////////////////////////////////////////////////
    // Counting
    ////////////////////////////////////////////////////////////////////

    apc_ratio_t cnt; // Ticks into current period
    apc_ratio_t eff; // Clamped ratio
    apc_ratio_t half; // Tick at which the level rises
    apc_ratio_t cnt_inc; // Count plus one
    logic wrap; // Last tick of a period
    logic go_high; // Rising point reached

    assign eff = apc_eff_ratio(ratio_i);
    assign half = {1'b0, eff[7:1]};
    assign cnt_inc = cnt + 8'h01;
    assign wrap = tick_i && (cnt_inc == eff);
    assign go_high = tick_i && !wrap && (cnt_inc == half);

    // Held idle low with count at zero while not running
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 8'h00;
            level_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else if (!run_i) begin
            cnt <= 8'h00;
            level_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            cnt <= wrap ? 8'h00 : (tick_i ? cnt_inc : cnt);
            level_o <= wrap ? 1'b0 : (go_high ? 1'b1 : level_o);
            rise_o <= go_high;
            fall_o <= wrap;
        end
    end

endmodule : apc_clk_divider

// ---- core/apc_top.sv ----
// Audio serial port clock direction, polarity and master clock logic.
// Assumes register port and pins are synchronous to core_clk_i,
// and that core_clk_i serves as the master clock for the dividers.
`timescale 1ns/1ns

module apc_top
    import apc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire apc_byte_t reg_addr_i,
    input wire apc_byte_t reg_wdata_i,
    output apc_byte_t reg_rdata_o,
    output logic reg_rvalid_o,
    // Divide ratios from the clock setup logic
    input wire apc_ratio_t bit_clock_divide_ratio_i,
    input wire apc_ratio_t frame_clock_divide_ratio_i,
    // Bit clock pin
    input wire logic bclk_pin_i,
    output logic bclk_pin_o,
    output logic bclk_pin_oe_o,
    // Frame clock pin
    input wire logic fclk_pin_i,
    output logic fclk_pin_o,
    output logic fclk_pin_oe_o,
    // Serial data in from the audio source
    input wire logic serial_in_i,
    // Serial out pin
    input wire logic serial_out_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_o,
    // Data to launch on the serial out pin
    input wire logic serial_out_data_i,
    // Captured serial stream
    output logic sample_strobe_o,
    output logic sample_data_o,
    output logic sample_frame_o,
    output logic serial_out_pin_level_o,
    // Mute path
    input wire logic mute_req_i,
    output logic power_mute_o
);

    ////////////////////////////////////////////////////////////////////
    // Registers
    ////////////////////////////////////////////////////////////////////

    apc_byte_t output_enable_ctrl; // Mute and serial out enables
    apc_byte_t serial_clock_direction_polarity; // Pin dirs, polarity
    apc_byte_t master_divider_reset_ctrl; // Divider run bits

    // Address decode
    logic hit_out_en;
    logic hit_dir_pol;
    logic hit_div_rst;

    assign hit_out_en = (reg_addr_i == `APC_OFS_OUT_EN);
    assign hit_dir_pol = (reg_addr_i == `APC_OFS_DIR_POL);
    assign hit_div_rst = (reg_addr_i == `APC_OFS_DIV_RST);

    // Read data select, unmapped reads give zero
    apc_byte_t next_rdata;

    assign next_rdata = hit_out_en ? output_enable_ctrl :
                        hit_dir_pol ? serial_clock_direction_polarity :
                        hit_div_rst ? master_divider_reset_ctrl :
                        8'h00;

    // Register writes, unmapped writes are dropped
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            output_enable_ctrl <= `APC_RST_OUT_EN;
            serial_clock_direction_polarity <= `APC_RST_DIR_POL;
            master_divider_reset_ctrl <= `APC_RST_DIV_RST;
        end else if (reg_wr_i) begin
            if (hit_out_en) begin
                output_enable_ctrl <= reg_wdata_i;
            end
            if (hit_dir_pol) begin
                serial_clock_direction_polarity <= reg_wdata_i;
            end
            if (hit_div_rst) begin
                master_divider_reset_ctrl <= reg_wdata_i;
            end
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? next_rdata : reg_rdata_o;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Field views
    ////////////////////////////////////////////////////////////////////

    logic mute_forward_enable; // Mute path open
    logic serial_out_pin_drive_enable; // Serial out driven
    logic bit_clock_invert; // Transitions on rising edge
    logic bit_clock_output_enable; // Bit clock master
    logic frame_clock_output_enable; // Frame clock master
    logic bit_clock_divider_run; // Bit clock divider released
    logic frame_clock_divider_run; // Frame clock divider released

    assign mute_forward_enable =
        output_enable_ctrl[`APC_BIT_MUTE_FWD];
    assign serial_out_pin_drive_enable =
        output_enable_ctrl[`APC_BIT_SER_OUT_OE];
    assign bit_clock_invert =
        serial_clock_direction_polarity[`APC_BIT_BCLK_INV];
    assign bit_clock_output_enable =
        serial_clock_direction_polarity[`APC_BIT_BCLK_OE];
    assign frame_clock_output_enable =
        serial_clock_direction_polarity[`APC_BIT_FCLK_OE];
    assign bit_clock_divider_run =
        master_divider_reset_ctrl[`APC_BIT_BCLK_RUN];
    assign frame_clock_divider_run =
        master_divider_reset_ctrl[`APC_BIT_FCLK_RUN];

    ////////////////////////////////////////////////////////////////////
    // Master clock generation
    ////////////////////////////////////////////////////////////////////

    logic gen_bclk; // Generated bit clock level
    logic gen_bclk_rise; // Generated bit clock rising
    logic gen_bclk_fall; // Generated bit clock falling
    logic gen_fclk; // Generated frame clock level
    logic fclk_tick; // One bit clock period elapsed

    // Bit clock counts every master clock cycle
    apc_clk_divider u_bclk_div (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .run_i(bit_clock_divider_run),
        .tick_i(1'b1),
        .ratio_i(bit_clock_divide_ratio_i),
        .level_o(gen_bclk),
        .rise_o(gen_bclk_rise),
        .fall_o(gen_bclk_fall)
    );

    // Frame clock steps on the bit clock transition edge
    assign fclk_tick = bit_clock_invert ? gen_bclk_rise : gen_bclk_fall;

    apc_clk_divider u_fclk_div (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .run_i(frame_clock_divider_run),
        .tick_i(fclk_tick),
        .ratio_i(frame_clock_divide_ratio_i),
        .level_o(gen_fclk),
        .rise_o(),
        .fall_o()
    );

    ////////////////////////////////////////////////////////////////////
    // Pin drive
    ////////////////////////////////////////////////////////////////////

    // Clock pins carry generated clocks when set as outputs
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bclk_pin_o <= 1'b0;
            bclk_pin_oe_o <= 1'b0;
            fclk_pin_o <= 1'b0;
            fclk_pin_oe_o <= 1'b0;
        end else begin
            bclk_pin_o <= gen_bclk;
            bclk_pin_oe_o <= bit_clock_output_enable;
            fclk_pin_o <= gen_fclk;
            fclk_pin_oe_o <= frame_clock_output_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial sampling
    ////////////////////////////////////////////////////////////////////

    logic bclk_now; // Bit clock in use
    logic fclk_now; // Frame clock in use
    logic bclk_prev; // Bit clock one cycle earlier
    logic bclk_rise; // Rising edge seen
    logic bclk_fall; // Falling edge seen
    logic sample_edge; // Edge on which data is steady
    logic launch_edge; // Edge on which data changes

    // Master uses own clocks, slave uses the pins
    assign bclk_now = bit_clock_output_enable ? gen_bclk : bclk_pin_i;
    assign fclk_now = frame_clock_output_enable ? gen_fclk : fclk_pin_i;
    assign bclk_rise = bclk_now && !bclk_prev;
    assign bclk_fall = !bclk_now && bclk_prev;

    // Normal mode changes on falling, inverted on rising
    assign launch_edge = bit_clock_invert ? bclk_rise : bclk_fall;
    assign sample_edge = bit_clock_invert ? bclk_fall : bclk_rise;

    // Edge history; source data relies on clocks in use
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bclk_prev <= 1'b0;
        end else begin
            bclk_prev <= bclk_now;
        end
    end

    // Capture data and frame on the steady edge
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sample_strobe_o <= 1'b0;
            sample_data_o <= 1'b0;
            sample_frame_o <= 1'b0;
        end else begin
            sample_strobe_o <= sample_edge;
            if (sample_edge) begin
                sample_data_o <= serial_in_i;
                sample_frame_o <= fclk_now;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial out pin
    ////////////////////////////////////////////////////////////////////

    // Launch output data on the transition edge
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_out_pin_o <= 1'b0;
            serial_out_pin_oe_o <= 1'b0;
            serial_out_pin_level_o <= 1'b0;
        end else begin
            if (launch_edge) begin
                serial_out_pin_o <= serial_out_data_i;
            end
            serial_out_pin_oe_o <= serial_out_pin_drive_enable;
            // Pin level seen while it is an input
            serial_out_pin_level_o <= serial_out_pin_drive_enable ?
                1'b0 : serial_out_pin_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mute forwarding
    ////////////////////////////////////////////////////////////////////

    // Mute reaches power stage only when enabled
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            power_mute_o <= 1'b0;
        end else begin
            power_mute_o <= mute_forward_enable && mute_req_i;
        end
    end

endmodule : apc_top

// ---- testbench/apc_top_asserts.sv ----
// Checker for the audio port clock block, bound to apc_top.
// Assumes registers change only through the register port.
`timescale 1ns/1ns

module apc_top_asserts
    import apc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire apc_byte_t reg_addr_i,
    input wire apc_byte_t reg_wdata_i,
    input wire apc_byte_t reg_rdata_o,
    input wire logic reg_rvalid_o,
    // Clocks, pins and mute
    input wire apc_ratio_t bit_clock_divide_ratio_i,
    input wire logic bclk_pin_o,
    input wire logic bclk_pin_oe_o,
    input wire logic fclk_pin_o,
    input wire logic fclk_pin_oe_o,
    input wire logic serial_out_pin_oe_o,
    input wire logic sample_strobe_o,
    input wire logic mute_req_i,
    input wire logic power_mute_o
);
    apc_byte_t sh08, sh09, sh0c; // Mirror of stored registers
    apc_byte_t exp_rd; // Expected read data
    apc_ratio_t nb; // Effective bit ratio
    logic [5:0] age; // Cycles since last write or stop
    logic [7:0] hi_n, lo_n; // Length of current clock level
    assign nb = (bit_clock_divide_ratio_i < 8'h02) ? 8'h02
        : bit_clock_divide_ratio_i;
    assign exp_rd = (reg_addr_i == 8'h08) ? sh08 : (reg_addr_i == 8'h09)
        ? sh09 : (reg_addr_i == 8'h0c) ? sh0c : 8'h00;
    ////////////////////////////////////////////////////////////////////
    // Mirror and level counters
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh08 <= 8'h00;
            sh09 <= 8'h00;
            sh0c <= 8'h01;
            age <= 6'h00;
            hi_n <= 8'h00;
            lo_n <= 8'h00;
        end else begin
            if (reg_wr_i && reg_addr_i == 8'h08) sh08 <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == 8'h09) sh09 <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == 8'h0c) sh0c <= reg_wdata_i;
            age <= (reg_wr_i || !sh0c[1]) ? 6'h00
                : (age == 6'h3f) ? age : age + 6'h01;
            hi_n <= bclk_pin_o ? hi_n + 8'h01 : 8'h00;
            lo_n <= bclk_pin_o ? 8'h00 : lo_n + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////
    AST_MUTE_FWD: assert property (
        power_mute_o == $past(sh08[4] && mute_req_i))
        else $error("mute forward mismatch");
    AST_BCLK_DIR: assert property (
        bclk_pin_oe_o == $past(sh09[4])) else $error("bit pin dir");
    AST_FCLK_DIR: assert property (
        fclk_pin_oe_o == $past(sh09[0])) else $error("frame pin dir");
    AST_SOUT_DIR: assert property (
        serial_out_pin_oe_o == $past(sh08[5])) else $error("out pin dir");
    AST_READ: assert property (
        reg_rd_i |=> reg_rvalid_o && reg_rdata_o == $past(exp_rd))
        else $error("read data mismatch");
    AST_RVALID: assert property (
        reg_rvalid_o == $past(reg_rd_i)) else $error("read valid");
    AST_BCLK_IDLE: assert property (
        !sh0c[1] [*3] |-> !bclk_pin_o) else $error("bit clock not idle");
    AST_FCLK_IDLE: assert property (
        !sh0c[0] [*3] |-> !fclk_pin_o) else $error("frame clock not idle");
    AST_BCLK_HIGH: assert property (
        $fell(bclk_pin_o) && age > 6'd40 && nb <= 8'd16
        |-> hi_n == nb - nb / 2) else $error("bit clock high time");
    AST_BCLK_LOW: assert property (
        $rose(bclk_pin_o) && age > 6'd40 && nb <= 8'd16
        |-> lo_n == nb / 2) else $error("bit clock low time");
    AST_SAMPLE_EDGE: assert property (
        sample_strobe_o && bclk_pin_oe_o && age > 6'd40 && nb >= 8'd8
        && nb <= 8'd16 |-> bclk_pin_o == !sh09[5])
        else $error("sampled on wrong edge");
    cover property ($rose(bclk_pin_o));
    cover property (power_mute_o);
    cover property (sample_strobe_o && sh09[5]);
endmodule : apc_top_asserts

bind apc_top apc_top_asserts apc_top_asserts_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .bit_clock_divide_ratio_i(bit_clock_divide_ratio_i),
    .bclk_pin_o(bclk_pin_o), .bclk_pin_oe_o(bclk_pin_oe_o),
    .fclk_pin_o(fclk_pin_o), .fclk_pin_oe_o(fclk_pin_oe_o),
    .serial_out_pin_oe_o(serial_out_pin_oe_o),
    .sample_strobe_o(sample_strobe_o), .mute_req_i(mute_req_i),
    .power_mute_o(power_mute_o));

// ---- testbench/apc_audio_src.sv ----
// Behavioural audio source that feeds serial data to the block.
// Assumes it shares the core clock and sees the block's bit clock.
`timescale 1ns/1ns

module apc_audio_src (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Clock view and polarity
    input wire logic bclk_oe_i,
    input wire logic bclk_gen_i,
    input wire logic invert_i,
    // Source outputs
    output logic bclk_o,
    output logic fclk_o,
    output logic data_o
);
    logic [5:0] cnt; // Free count for slave clocks
    logic prev; // Clock level one cycle back
    logic clk_use; // Clock the data is timed to
    logic hit; // Transition edge seen
    assign bclk_o = cnt[2] ^ invert_i;
    assign fclk_o = cnt[5];
    assign clk_use = bclk_oe_i ? bclk_gen_i : bclk_o;
    assign hit = invert_i ? (clk_use && !prev) : (!clk_use && prev);
    // Data toggles on each transition edge of the clock in use
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 6'h00;
            prev <= 1'b0;
            data_o <= 1'b0;
        end else begin
            cnt <= cnt + 6'h01;
            prev <= clk_use;
            if (hit) data_o <= !data_o;
        end
    end
endmodule : apc_audio_src

// ---- testbench/apc_top_tb_top.sv ----
// Testbench for the audio port clock master block.
// Assumes the checker binds itself and the source model is compiled.
`timescale 1ns/1ns

module apc_top_tb_top
    import apc_pkg::*;
;
    logic core_clk_i = 1'b0, nrst_i, reg_wr_i, reg_rd_i, mute_req_i;
    logic sop_in, inv, watch, have, last;
    apc_byte_t reg_addr_i, reg_wdata_i, reg_rdata_o;
    apc_ratio_t nb, nf;
    logic reg_rvalid_o, bclk_pin_o, bclk_pin_oe_o, fclk_pin_o;
    logic fclk_pin_oe_o, serial_out_pin_o, serial_out_pin_oe_o;
    logic sample_strobe_o, sample_data_o, lvl, power_mute_o;
    logic sample_frame_o, sod; // Captured frame, data to launch
    logic src_b, src_f, src_d;
    int fail_count = 0, comparisons = 0, strobes = 0, s0, cycles = 0;
    int fhi = 0, f0; // Strobes that saw the frame clock high
    apc_byte_t ofs [3] = '{8'h08, 8'h09, 8'h0c};
    apc_byte_t pat [2] = '{8'ha5, 8'h5a};

    apc_top apc_top_inst (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .bit_clock_divide_ratio_i(nb),
        .frame_clock_divide_ratio_i(nf),
        .bclk_pin_i(bclk_pin_oe_o ? bclk_pin_o : src_b),
        .bclk_pin_o(bclk_pin_o), .bclk_pin_oe_o(bclk_pin_oe_o),
        .fclk_pin_i(fclk_pin_oe_o ? fclk_pin_o : src_f),
        .fclk_pin_o(fclk_pin_o), .fclk_pin_oe_o(fclk_pin_oe_o),
        .serial_in_i(src_d),
        .serial_out_pin_i(serial_out_pin_oe_o ? serial_out_pin_o : sop_in),
        .serial_out_pin_o(serial_out_pin_o),
        .serial_out_pin_oe_o(serial_out_pin_oe_o),
        .serial_out_data_i(sod), .sample_strobe_o(sample_strobe_o),
        .sample_data_o(sample_data_o), .sample_frame_o(sample_frame_o),
        .serial_out_pin_level_o(lvl), .mute_req_i(mute_req_i),
        .power_mute_o(power_mute_o));

    apc_audio_src apc_audio_src_inst (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .bclk_oe_i(bclk_pin_oe_o),
        .bclk_gen_i(bclk_pin_o), .invert_i(inv), .bclk_o(src_b),
        .fclk_o(src_f), .data_o(src_d));

    always #4 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input apc_byte_t got, input apc_byte_t exp);
        comparisons++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    task automatic wr(input apc_byte_t a, input apc_byte_t d);
        @(posedge core_clk_i);
        #1;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge core_clk_i);
        #1;
        reg_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input apc_byte_t a, input apc_byte_t e);
        @(posedge core_clk_i);
        #1;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge core_clk_i);
        #1;
        reg_rd_i = 1'b0;
        chk({7'h00, reg_rvalid_o}, 8'h01);
        chk(reg_rdata_o, e);
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : wait_cyc

    // Cycles between two rises of the bit or frame clock
    task automatic per(input bit f, input apc_byte_t exp);
        int n, r;
        logic p, c;
        n = 0;
        r = 0;
        p = 1'b1;
        for (int i = 0; i < 300 && r < 2; i++) begin
            @(posedge core_clk_i);
            #1;
            c = f ? fclk_pin_o : bclk_pin_o;
            if (r == 1) n++;
            if (c === 1'b1 && p === 1'b0) r++;
            p = c;
        end
        chk(n[7:0], exp);
    endtask : per

    task automatic wrap_up();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////
    // Strobe count and alternation of captured data
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
        if (sample_strobe_o === 1'b1) begin
            strobes++;
            if (watch && sample_frame_o === 1'b1) fhi++;
            if (watch && have) begin
                chk({7'h00, sample_data_o}, {7'h00, !last});
            end
            have = watch;
            last = sample_data_o;
        end
    end

    initial begin
        {nrst_i, reg_wr_i, reg_rd_i, mute_req_i, inv, watch, have} = 7'h00;
        {reg_addr_i, reg_wdata_i, last, sop_in, sod} = 19'h00002;
        nb = 8'h04;
        nf = 8'h04;
        repeat (8) @(posedge core_clk_i);
        #1;
        nrst_i = 1'b1;
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h00);
        rd(8'h0c, 8'h01);
        wr(8'h0d, 8'hff);
        rd(8'h0d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i % 3], pat[i / 3]);
            rd(ofs[i % 3], pat[i / 3]);
        end
        mute_req_i = 1'b1;
        wr(8'h08, 8'h10);
        wait_cyc(2);
        chk({power_mute_o, serial_out_pin_oe_o, lvl}, 8'h05);
        wr(8'h08, 8'h20);
        wait_cyc(2);
        chk({power_mute_o, serial_out_pin_oe_o, lvl}, 8'h02);
        wr(8'h09, 8'h11);
        wr(8'h0c, 8'h03);
        chk({bclk_pin_oe_o, fclk_pin_oe_o}, 8'h03);
        per(1'b0, 8'd4);
        per(1'b1, 8'd16);
        for (int k = 0; k < 2; k++) begin
            wr(8'h0c, 8'h00);
            // Ratio only changes while the divider is held
            nb = 8'h08;
            wait_cyc(4);
            chk({bclk_pin_o, fclk_pin_o}, 8'h00);
            inv = k[0];
            sod = !k[0];
            wr(8'h09, k ? 8'h31 : 8'h11);
            {watch, have} = 2'b10;
            s0 = strobes;
            f0 = fhi;
            wr(8'h0c, 8'h03);
            wait_cyc(100);
            chk({7'h00, strobes - s0 >= 11}, 8'h01);
            // Frame of four bit periods: half the samples see it high
            chk({7'h00, fhi - f0 >= 5 && fhi - f0 <= 7}, 8'h01);
            chk({7'h00, serial_out_pin_o}, {7'h00, sod});
            per(1'b0, 8'd8);
        end
        // Stop watching while clocks are switched over
        {watch, have} = 2'b00;
        wr(8'h0c, 8'h00);
        wr(8'h09, 8'h00);
        inv = 1'b0;
        {watch, have} = 2'b10;
        s0 = strobes;
        wait_cyc(200);
        chk({bclk_pin_oe_o, strobes - s0 >= 23}, 8'h01);
        wrap_up();
    end
endmodule : apc_top_tb_top
